// ==== hdl/gtc_consts.vh ====
// Constants for the gated 16-bit timer/counter: offsets, fields, codes
`ifndef GTC_CONSTS_VH
`define GTC_CONSTS_VH

// ==========================================================
// Register byte offsets on the APB
`define GTC_OFF_CTRL      8'h00
`define GTC_OFF_GATE      8'h04
`define GTC_OFF_CNT_LO    8'h08
`define GTC_OFF_CNT_HI    8'h0C
`define GTC_OFF_STATUS    8'h10
`define GTC_OFF_INT_CLR   8'h14
`define GTC_OFF_INT_EN    8'h18

// ==========================================================
// Timer control register fields
`define GTC_CTRL_RUN      0
`define GTC_CTRL_SYNCDIS  2
`define GTC_CTRL_OSCEN    3
`define GTC_CTRL_PS_LO    4
`define GTC_CTRL_PS_HI    5
`define GTC_CTRL_CS_LO    6
`define GTC_CTRL_CS_HI    7
`define GTC_CTRL_RST      8'h00
`define GTC_CTRL_MASK     8'hFD

// Gate control register fields
`define GTC_GATE_EN       0
`define GTC_GATE_RST      1'h0

// Status, clear and enable share one layout
`define GTC_INT_OVF       0

// ==========================================================
// Clock source codes
`define GTC_CS_INST       2'h0
`define GTC_CS_SYS        2'h1
`define GTC_CS_EXT        2'h2
`define GTC_CS_LFOSC      2'h3

// Instruction cycle is four system clocks
`define GTC_PHASE_LAST    2'h3
`define GTC_CNT_MAX       16'hFFFF
`define GTC_CNT_RST       16'h0000

`endif

// ==== hdl/gtc_sync.v ====
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module gtc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             rst,
  // Levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ==== hdl/gtc_prescale.v ====
// Hidden 1/2/4/8 prescaler in front of the 16-bit count
`timescale 1ns/1ps
module gtc_prescale #(
  parameter PS_W = 3
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Control
  input  wire [1:0] div_sel,
  input  wire       clr,
  // Input ticks and divided output
  input  wire       tick_in,
  output wire       tick_out
);

  reg  [PS_W-1:0] cnt_r;
  reg  [PS_W-1:0] cnt_nxt;
  wire [PS_W-1:0] mask;

  // Mask of low bits that must all be one before passing a tick
  assign mask     = (div_sel == 2'h0) ? 3'h0 :
                    (div_sel == 2'h1) ? 3'h1 :
                    (div_sel == 2'h2) ? 3'h3 : 3'h7;
  assign tick_out = tick_in & ((cnt_r & mask) == mask);

  // Count ticks; a count write restarts the division
  always @*
  begin
    cnt_nxt = cnt_r;
    if (clr)
      cnt_nxt = {PS_W{1'b0}};
    else if (tick_in)
      cnt_nxt = cnt_r + 3'h1;
  end

  // Not visible on the bus at all
  always @(posedge sys_clk)
  begin
    if (rst)
      cnt_r <= {PS_W{1'b0}};
    else
      cnt_r <= cnt_nxt;
  end

endmodule

// ==== hdl/gtc_top.v ====
// Gated 16-bit timer/counter with APB registers and overflow interrupt
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "gtc_consts.vh"
module gtc_top #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 16
) (
  // Clock and reset
  input  wire              sys_clk,
  input  wire              rst,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Clock source pins and core state
  input  wire              external_clock_input,
  input  wire              crystal_in_pin,
  input  wire              low_freq_internal_osc,
  input  wire              gate_pin,
  input  wire              core_sleep,
  // Oscillator drive, interrupt and wake
  output reg               crystal_out_pin,
  output reg               irq,
  output reg               wake_req
);

  // ==========================================================
  // Declarations
  reg  [7:0]       timer_control_reg_r;
  reg              gate_enable_bit_r;
  reg  [CNT_W-1:0] count_r;
  reg  [CNT_W-1:0] count_nxt;
  reg              overflow_flag_r;
  reg              ovf_enable_r;
  reg  [1:0]       phase_r;
  reg              src_prev_r;
  reg              armed_r;
  reg              armed_nxt;
  reg              pend_r;
  reg              pend_nxt;
  reg              raw_tick;
  reg              eff_tick;

  wire [2:0]       pins_s;
  wire             ext_s;
  wire             sosc_s;
  wire             lf_s;
  wire             gate_s;
  wire             run_bit;
  wire             sync_disable_bit;
  wire             secondary_osc_enable;
  wire [1:0]       prescale_select_field;
  wire [1:0]       clock_source_field;
  wire             src_lvl;
  wire             src_rise;
  wire             src_fall;
  wire             inst_edge;
  wire             is_ext;
  wire             count_on;
  wire             frozen;
  wire             ps_tick;
  wire             inc;
  wire             setup;
  wire             acc_wr;
  wire             wr_lo;
  wire             wr_hi;
  wire             cnt_wr;
  wire             ovf_set;
  wire             ovf_clr;

  // ==========================================================
  // Register field decode
  assign run_bit               = timer_control_reg_r[`GTC_CTRL_RUN];
  assign sync_disable_bit      = timer_control_reg_r[`GTC_CTRL_SYNCDIS];
  assign secondary_osc_enable  = timer_control_reg_r[`GTC_CTRL_OSCEN];
  assign prescale_select_field =
    timer_control_reg_r[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO];
  assign clock_source_field    =
    timer_control_reg_r[`GTC_CTRL_CS_HI:`GTC_CTRL_CS_LO];

  // Byte-lane check: narrow registers live in lane 0
  function lane0_hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] off;
    input [3:0]        strb;
    begin
      lane0_hit = (addr == off) && strb[0];
    end
  endfunction

  // ==========================================================
  // APB strobes; a write lands at the edge that samples pready
  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pready & pwrite;
  assign wr_lo  = acc_wr & lane0_hit(paddr, `GTC_OFF_CNT_LO, pstrb);
  assign wr_hi  = acc_wr & lane0_hit(paddr, `GTC_OFF_CNT_HI, pstrb);
  assign cnt_wr = wr_lo | wr_hi;
  assign ovf_clr = acc_wr & lane0_hit(paddr, `GTC_OFF_INT_CLR, pstrb)
                   & pwdata[`GTC_INT_OVF];

  // ==========================================================
  // Pin synchronisers: pins never reach logic before two flops
  gtc_sync #(
    .WIDTH    (3)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({external_clock_input, crystal_in_pin,
                low_freq_internal_osc}),
    .sync_out (pins_s)
  );

  gtc_sync #(
    .WIDTH    (1)
  ) u_gate_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (gate_pin),
    .sync_out (gate_s)
  );

  assign ext_s  = pins_s[2];
  assign sosc_s = pins_s[1];
  assign lf_s   = pins_s[0];

  // ==========================================================
  // Source level and its edges
  assign is_ext  = (clock_source_field == `GTC_CS_EXT);
  assign src_lvl = (clock_source_field == `GTC_CS_LFOSC) ? lf_s :
                   (secondary_osc_enable ? sosc_s : ext_s);
  assign src_rise  = src_lvl & ~src_prev_r;
  assign src_fall  = ~src_lvl & src_prev_r;
  assign inst_edge = (phase_r == `GTC_PHASE_LAST);

  // Instruction phase counter, four system clocks per cycle
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      phase_r    <= 2'h0;
      src_prev_r <= 1'b0;
    end
    else
    begin
      phase_r    <= phase_r + 2'h1;
      src_prev_r <= src_lvl;
    end
  end

  // ==========================================================
  // Enable: run bit off wins, gate only matters with gate enable
  assign count_on = run_bit & (~gate_enable_bit_r | gate_s);

  // In sleep the core clocks stop; only unsynced pin counting runs
  assign frozen = core_sleep & ~(is_ext & sync_disable_bit);

  // Raw tick per source, before sync alignment and prescaler
  always @*
  begin
    raw_tick = 1'b0;
    case (clock_source_field)
      `GTC_CS_INST:  raw_tick = inst_edge;
      `GTC_CS_SYS:   raw_tick = 1'b1;
      `GTC_CS_EXT:   raw_tick = src_rise & armed_r;
      `GTC_CS_LFOSC: raw_tick = src_rise;
      default:       raw_tick = 1'b0;
    endcase
  end

  // Synced pin edges wait for the instruction boundary; unsynced pass
  // straight through. Switching modes may drop or add one held edge.
  always @*
  begin
    pend_nxt = pend_r;
    eff_tick = raw_tick;
    if (is_ext && !sync_disable_bit)
    begin
      eff_tick = 1'b0;
      if (inst_edge)
      begin
        eff_tick = pend_r | raw_tick;
        pend_nxt = 1'b0;
      end
      else if (raw_tick)
        pend_nxt = 1'b1;
    end
    else
      pend_nxt = 1'b0;
    if (cnt_wr || !run_bit)
      pend_nxt = 1'b0;
  end

  // External source: a falling edge must be seen before the first counted rising edge
  always @*
  begin
    armed_nxt = armed_r;
    if (cnt_wr || !run_bit)
      armed_nxt = 1'b0;
    else if (is_ext && src_fall)
      armed_nxt = 1'b1;
  end

  // ==========================================================
  // Prescaler between the selected tick and the count
  gtc_prescale #(
    .PS_W     (3)
  ) u_prescale (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .div_sel  (prescale_select_field),
    .clr      (cnt_wr),
    .tick_in  (eff_tick & count_on & ~frozen),
    .tick_out (ps_tick)
  );

  assign inc     = ps_tick & ~cnt_wr;
  assign ovf_set = inc & (count_r == `GTC_CNT_MAX);

  // ==========================================================
  // Count: a byte write replaces its half and beats an increment
  always @*
  begin
    count_nxt = count_r;
    if (cnt_wr)
    begin
      if (wr_lo)
        count_nxt[7:0] = pwdata[7:0];
      if (wr_hi)
        count_nxt[15:8] = pwdata[7:0];
    end
    else if (inc)
      count_nxt = count_r + 16'h0001;
  end

  // Count, arming and pending state
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      count_r <= `GTC_CNT_RST;
      armed_r <= 1'b0;
      pend_r  <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      armed_r <= armed_nxt;
      pend_r  <= pend_nxt;
    end
  end

  // ==========================================================
  // Control registers; reset selects instruction clock, timer off
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      timer_control_reg_r <= `GTC_CTRL_RST;
      gate_enable_bit_r   <= `GTC_GATE_RST;
      ovf_enable_r        <= 1'b0;
    end
    else
    begin
      if (acc_wr && lane0_hit(paddr, `GTC_OFF_CTRL, pstrb))
        timer_control_reg_r <= pwdata[7:0] & `GTC_CTRL_MASK;
      if (acc_wr && lane0_hit(paddr, `GTC_OFF_GATE, pstrb))
        gate_enable_bit_r <= pwdata[`GTC_GATE_EN];
      if (acc_wr && lane0_hit(paddr, `GTC_OFF_INT_EN, pstrb))
        ovf_enable_r <= pwdata[`GTC_INT_OVF];
    end
  end

  // Sticky overflow; a rollover in the clear cycle keeps it set
  always @(posedge sys_clk)
  begin
    if (rst)
      overflow_flag_r <= 1'b0;
    else if (ovf_set)
      overflow_flag_r <= 1'b1;
    else if (ovf_clr)
      overflow_flag_r <= 1'b0;
  end

  // ==========================================================
  // Interrupt, wake and crystal drive, all registered
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq             <= 1'b0;
      wake_req        <= 1'b0;
      crystal_out_pin <= 1'b0;
    end
    else
    begin
      irq      <= overflow_flag_r & ovf_enable_r;
      wake_req <= overflow_flag_r & ovf_enable_r & core_sleep;
      // Oscillator keeps running whatever the sleep state
      crystal_out_pin <= secondary_osc_enable & ~sosc_s;
    end
  end

  // ==========================================================
  // APB answer: data captured in setup, zero wait states.
  // Count is in this clock domain, so a read is never torn.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (setup)
      begin
        case (paddr)
          `GTC_OFF_CTRL:
            prdata <= {24'h000000, timer_control_reg_r};
          `GTC_OFF_GATE:
            prdata <= {31'h00000000, gate_enable_bit_r};
          `GTC_OFF_CNT_LO:
            prdata <= {24'h000000, count_r[7:0]};
          `GTC_OFF_CNT_HI:
            prdata <= {24'h000000, count_r[15:8]};
          `GTC_OFF_STATUS:
            prdata <= {31'h00000000, overflow_flag_r};
          `GTC_OFF_INT_EN:
            prdata <= {31'h00000000, ovf_enable_r};
          `GTC_OFF_INT_CLR:
            prdata <= 32'h00000000;
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// ==== verification/gtc_top_properties.sv ====
// Port-level assertions for the gated timer/counter
`timescale 1ns/1ps
module gtc_top_properties #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 16
) (
  // Clock and reset
  input wire              sys_clk,
  input wire              rst,
  // APB
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  // Pins and interrupt
  input wire              crystal_in_pin,
  input wire              core_sleep,
  input wire              crystal_out_pin,
  input wire              irq,
  input wire              wake_req
);
  // ==========================================================
  // Helpers
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Writes that may drop the interrupt: clear or enable register
  wire clr_wr = psel && penable && pwrite && pready &&
                (paddr == 8'h14 || paddr == 8'h18);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  // ==========================================================
  // Properties
  ready_on_time_a: assert property (setup_s |=> access_s)
    else $error("pready missing in access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("pready without setup");
  err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  irq_sticky_a: assert property (
    irq && !clr_wr && !$past(clr_wr) |=> irq)
    else $error("interrupt dropped without clear");
  reset_quiet_a: assert property (
    disable iff (1'b0) rst |=> !irq && !pready && !wake_req)
    else $error("outputs active after reset");
  wake_sleep_a: assert property (
    wake_req |-> irq && $past(core_sleep))
    else $error("wake without sleep or interrupt");
  xtal_drive_a: assert property (
    crystal_in_pin [*4] |-> !crystal_out_pin)
    else $error("crystal drive not inverting");
endmodule

bind gtc_top gtc_top_properties #(.ADDR_W(ADDR_W), .CNT_W(CNT_W))
  gtc_top_properties_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .crystal_in_pin(crystal_in_pin),
  .core_sleep(core_sleep), .crystal_out_pin(crystal_out_pin),
  .irq(irq), .wake_req(wake_req));

// ==== verification/gtc_pin_model.sv ====
// External clock source model producing bursts of pin periods
`timescale 1ns/1ps
module gtc_pin_model #(
  parameter HALF = 4
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Burst request
  input  wire       start,
  input  wire [3:0] n_req,
  // Pin and status
  output reg        pin,
  output reg        busy
);
  reg [3:0] left_r;
  reg [3:0] ph_r;
  // ==========================================================
  // Burst generator; pin rests low so a burst opens with a rise
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin <= 1'b0;
      busy <= 1'b0;
      ph_r <= 4'h0;
      left_r <= 4'h0;
    end
    else if (start && !busy)
    begin
      left_r <= n_req;
      ph_r <= 4'h0;
      busy <= 1'b1;
    end
    else if (busy)
    begin
      pin <= (ph_r < HALF);
      ph_r <= (ph_r == 2 * HALF - 1) ? 4'h0 : ph_r + 4'h1;
      if (ph_r == 2 * HALF - 1)
      begin
        left_r <= left_r - 4'h1;
        busy <= (left_r != 4'h1);
      end
    end
  end
endmodule

// ==== verification/tb_gtc_top.sv ====
// Self-checking bench for the gated timer/counter
`timescale 1ns/1ps
`include "gtc_consts.vh"
module tb_gtc_top;
  localparam [31:0] EXT = 32'hC1898581;
  reg         sys_clk;
  reg         rst;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  reg  [3:0]  pstrb;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  reg  [1:0]  route;
  reg         gate_pin;
  reg         core_sleep;
  reg         start;
  wire        pin;
  wire        busy;
  wire        crystal_out_pin;
  wire        irq;
  wire        wake_req;
  reg  [31:0] rd;
  reg         err;
  reg  [7:0]  c0;
  integer     fails;
  integer     tests_run;
  integer     i;
  integer     k;
  integer     t;
  // ==========================================================
  // Design and far-side model
  gtc_top gtc_top_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_clock_input(pin & (route == 2'h0)),
    .crystal_in_pin(pin & (route == 2'h1)),
    .low_freq_internal_osc(pin & (route == 2'h2)),
    .gate_pin(gate_pin), .core_sleep(core_sleep),
    .crystal_out_pin(crystal_out_pin), .irq(irq), .wake_req(wake_req));
  gtc_pin_model gtc_pin_model_i (.sys_clk(sys_clk), .rst(rst),
    .start(start), .n_req(4'h5), .pin(pin), .busy(busy));
  // ==========================================================
  // Tasks
  task results;
  begin
    $display("%0d compared, %0d mismatched", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  end
  endtask
  // A used-up wait counts once and ends the run
  task bound(input integer lim);
  begin
    if (k >= lim)
    begin
      check(32'h0, 32'h1);
      results;
    end
  end
  endtask
  task step;
  begin
    t = t + 1;
    $display("test %0d done, %0d mismatched so far", t, fails);
  end
  endtask
  // Starts one edge late so no signal is driven twice in a step
  task apb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    for (k = 0; k < 20 && pready !== 1'b1; k = k + 1)
      @(posedge sys_clk);
    bound(20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    apb(1'b1, a, d);
  end
  endtask
  task rdck(input [7:0] a, input [31:0] e);
  begin
    apb(1'b0, a, 32'h0);
    check(rd, e);
  end
  endtask
  // Low byte growth over a 64-cycle window between setup edges
  task rate(input [7:0] ctl, input [7:0] exp);
  begin
    wr(`GTC_OFF_CTRL, ctl);
    apb(1'b0, `GTC_OFF_CNT_LO, 32'h0);
    c0 = rd[7:0];
    repeat (61) @(posedge sys_clk);
    apb(1'b0, `GTC_OFF_CNT_LO, 32'h0);
    c0 = rd[7:0] - c0;
    check(c0, exp);
  end
  endtask
  task burst;
  begin
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    for (k = 0; k < 200 && busy === 1'b1; k = k + 1)
      @(posedge sys_clk);
    bound(200);
    repeat (12) @(posedge sys_clk);
  end
  endtask
  // ==========================================================
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    route = 2'h0;
    gate_pin = 1'b0;
    core_sleep = 1'b0;
    start = 1'b0;
    fails = 0;
    tests_run = 0;
    t = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i = i + 1)
      rdck({i[5:0], 2'h0}, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check(err, 1'b1);
    wr(`GTC_OFF_CTRL, 32'hFF);
    rdck(`GTC_OFF_CTRL, `GTC_CTRL_MASK);
    wr(`GTC_OFF_CTRL, 32'h0);
    wr(`GTC_OFF_CNT_LO, 32'h34);
    wr(`GTC_OFF_CNT_HI, 32'h12);
    rdck(`GTC_OFF_CNT_LO, 32'h34);
    rdck(`GTC_OFF_CNT_HI, 32'h12);
    step;
    // Instruction and system clock at every prescale
    for (i = 0; i < 8; i = i + 1)
      rate({1'b0, i[0], i[2:1], 4'h1},
           8'h10 << (2 * i[0]) >> i[2:1]);
    wr(`GTC_OFF_GATE, 32'h1);
    rate(8'h41, 8'h00);
    gate_pin <= 1'b1;
    rate(8'h41, 8'h40);
    rate(8'h40, 8'h00);
    wr(`GTC_OFF_GATE, 32'h0);
    step;
    // Rollover, masking and clearing
    wr(`GTC_OFF_CTRL, 32'h0);
    wr(`GTC_OFF_INT_EN, 32'h1);
    wr(`GTC_OFF_CNT_HI, 32'hFF);
    wr(`GTC_OFF_CNT_LO, 32'hF0);
    wr(`GTC_OFF_CTRL, 32'h41);
    for (k = 0; k < 200 && irq !== 1'b1; k = k + 1)
      @(posedge sys_clk);
    bound(200);
    wr(`GTC_OFF_CTRL, 32'h0);
    rdck(`GTC_OFF_STATUS, 32'h1);
    wr(`GTC_OFF_INT_EN, 32'h0);
    rdck(`GTC_OFF_STATUS, 32'h1);
    check(irq, 1'b0);
    wr(`GTC_OFF_INT_EN, 32'h1);
    wr(`GTC_OFF_INT_CLR, 32'h1);
    rdck(`GTC_OFF_STATUS, 32'h0);
    check(irq, 1'b0);
    step;
    // Pin, crystal and slow oscillator sources
    for (i = 0; i < 4; i = i + 1)
    begin
      c0 = EXT[8*i +: 8];
      route <= (i < 2) ? 2'h0 : i[1:0] - 2'h1;
      wr(`GTC_OFF_CTRL, 32'h0);
      wr(`GTC_OFF_CNT_LO, 32'h0);
      wr(`GTC_OFF_CNT_HI, 32'h0);
      wr(`GTC_OFF_CTRL, c0);
      burst;
      check(crystal_out_pin, i == 2);
      rdck(`GTC_OFF_CNT_LO, (i == 3) ? 5 : 4);
      burst;
      rdck(`GTC_OFF_CNT_LO, (i == 3) ? 10 : 9);
    end
    step;
    // Unsynchronised pin counting through sleep
    route <= 2'h0;
    wr(`GTC_OFF_CTRL, 32'h0);
    wr(`GTC_OFF_CNT_HI, 32'hFF);
    wr(`GTC_OFF_CNT_LO, 32'hFF);
    core_sleep <= 1'b1;
    wr(`GTC_OFF_CTRL, 32'h85);
    burst;
    check(wake_req, 1'b1);
    core_sleep <= 1'b0;
    rdck(`GTC_OFF_CNT_LO, 32'h3);
    check(wake_req, 1'b0);
    step;
    // Settle delay in software: FC00h preload flags after 1024 ticks
    wr(`GTC_OFF_CTRL, 32'h0);
    wr(`GTC_OFF_CNT_HI, 32'hFC);
    wr(`GTC_OFF_CNT_LO, 32'h00);
    wr(`GTC_OFF_INT_CLR, 32'h1);
    wr(`GTC_OFF_CTRL, 32'h41);
    for (k = 0; k < 1100 && irq !== 1'b1; k = k + 1)
      @(posedge sys_clk);
    bound(1100);
    check(k > 1020 && k < 1030, 1'b1);
    wr(`GTC_OFF_CTRL, 32'h0);
    rdck(`GTC_OFF_STATUS, 32'h1);
    step;
    results;
  end
endmodule
